// *** verilog/frs_map.vh ***
`ifndef FRS_MAP_VH
`define FRS_MAP_VH
// Status byte 1 fields
`define FRS_S1_END_CYL      7
`define FRS_S1_CRC          5
`define FRS_S1_OVERRUN      4
`define FRS_S1_NO_SECTOR    2
`define FRS_S1_WP_VIOL      1
`define FRS_S1_NO_ID_MARK   0
// Status byte 2 fields
`define FRS_S2_CTRL_MARK    6
`define FRS_S2_DATA_CRC     5
`define FRS_S2_TRK_MISMATCH 4
`define FRS_S2_BAD_TRK      1
`define FRS_S2_NO_DATA_MARK 0
// Status byte 3 fields
`define FRS_S3_WP           6
`define FRS_S3_ONE_HI       5
`define FRS_S3_TRACK_ZERO_INPUT         4
`define FRS_S3_ONE_LO       3
`define FRS_S3_HEAD         2
// Constants
`define FRS_LAST_SECTOR     8'hFF
`define FRS_BAD_TRACK       8'hFF
`define FRS_INDEX_LIMIT     2'h2
`define FRS_RESET_VAL       8'h00
`define FRS_S3_FIXED        8'h28
// Command classes
`define FRS_CMD_NONE        3'h0
`define FRS_CMD_READ        3'h1
`define FRS_CMD_READ_DEL    3'h2
`define FRS_CMD_READ_ID     3'h3
`define FRS_CMD_READ_TRACK  3'h4
`define FRS_CMD_WRITE       3'h5
`define FRS_CMD_WRITE_DEL   3'h6
`define FRS_CMD_FORMAT      3'h7
// Result selectors
`define FRS_SEL_ONE         2'h1
`define FRS_SEL_TWO         2'h2
`define FRS_SEL_THREE       2'h3
`endif

// *** verilog/frs_reset_ctrl.v ***
`timescale 1ns/1ps
`include "frs_map.vh"
module frs_reset_ctrl (
	// Clock and pin reset
	input  wire clock,
	input  wire nrst,
	// Software reset requests
	input  wire dor_reset_set,
	input  wire dor_reset_clear,
	input  wire rate_reset_pulse,
	// Results
	output reg  dor_reset_r,
	output reg  core_reset_r,
	output reg  power_down_exit_r
);
	reg rate_reset_r;

	// Output-register reset holds until cleared; rate reset lasts one cycle
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dor_reset_r       <= 1'b1;
			rate_reset_r      <= 1'b0;
			core_reset_r      <= 1'b1;
			power_down_exit_r <= 1'b0;
		end else begin
			if (dor_reset_set)
				dor_reset_r <= 1'b1;
			else if (dor_reset_clear)
				dor_reset_r <= 1'b0;
			rate_reset_r      <= rate_reset_pulse & ~rate_reset_r;
			core_reset_r      <= dor_reset_r | dor_reset_set | rate_reset_r;
			power_down_exit_r <= dor_reset_set | rate_reset_pulse | dor_reset_r;
		end
	end
endmodule

// *** verilog/frs_result_status.v ***
`timescale 1ns/1ps
`include "frs_map.vh"
// Functional notes
// - Flag end of track on sector overrun or data command ending without terminal count.
// - Flag CRC error found in id field or data field.
// - Flag late host or DMA service causing overrun or underrun.
// - Flag missing sector, failed id read or bad track sequence.
// - Flag write-protect going high during write or format commands.
// - Flag no id mark after two index pulses, or no data mark.
// - Unused bits of bytes one, two and three read zero.
// - Byte three bits five and three always read one.
// - Flag control mark on wrong kind of data address mark.
// - Flag CRC error in the data field.
// - Flag track read from id differing from internal track.
// - Flag bad track when mismatched id track equals FF.
// - Flag missing data mark only; a deleted data mark sets the control mark on the read data command only, not on read deleted.
// - Byte three mirrors write-protect, track zero, head and drive selects.
// - Pin, output-register and rate-register resets all reset and wake the core.
// - Power-on reset initialises the controller.
// - Pin reset aborts operations and returns to idle.
// - Leaving reset clears configure settings and waits for a command.
// - Drive polling starts after reset unless configure disables it.
// - Rate reset self-clears; output-register reset held by host and wins.
// - Pin reset clears all registers including specify values, sets output-register reset.
// - Status bytes are presented through the data register in result phase.
module frs_result_status #(
	parameter TRACK_W = 8
) (
	// Clock and reset
	input  wire               clock,
	input  wire               nrst,
	// Command context from the sequencer
	input  wire               cmd_start,
	input  wire [2:0]         cmd_class,
	input  wire               cmd_end,
	input  wire               terminal_count,
	input  wire [7:0]         sector_num,
	input  wire [TRACK_W-1:0] id_track,
	input  wire [TRACK_W-1:0] internal_track,
	input  wire               id_valid,
	// Error events from the data path
	input  wire               id_crc_err,
	input  wire               data_crc_err,
	input  wire               service_late,
	input  wire               sector_not_found,
	input  wire               sequence_err,
	input  wire               index_pulse_input,
	input  wire               id_mark_seen,
	input  wire               data_mark_missing,
	input  wire               deleted_mark_seen,
	input  wire               normal_mark_seen,
	// Drive cable inputs
	input  wire               write_protect_input,
	input  wire               track_zero_input,
	// Drive outputs to mirror
	input  wire               head_side_output,
	input  wire [1:0]         drive_select_out,
	// Host data register read
	input  wire               result_read,
	input  wire [1:0]         result_sel,
	input  wire               results_done,
	// Software resets, configure and specify writes
	input  wire               dor_reset_set,
	input  wire               dor_reset_clear,
	input  wire               rate_reset_pulse,
	input  wire               cfg_poll_disable,
	input  wire               cfg_write,
	input  wire [7:0]         specify_in,
	input  wire               specify_write,
	// Outputs
	output reg  [7:0]         data_out_r,
	output reg                idle_r,
	output reg                poll_enable_r,
	output reg                dor_reset_out_r,
	output reg                awake_r,
	output reg  [7:0]         specify_r
);
	localparam ST_IDLE = 2'h0;
	localparam ST_EXEC = 2'h1;
	localparam ST_HOLD = 2'h2;

	reg [1:0]         state_r;
	reg [2:0]         class_r;
	reg [1:0]         index_cnt_r;
	reg               id_seen_r;
	reg [7:0]         s1_live_r;
	reg [7:0]         s2_live_r;
	reg [7:0]         s1_r;
	reg [7:0]         s2_r;
	reg               wp_m_r;
	reg               wp_s_r;
	reg               wp_d_r;
	reg               t0_m_r;
	reg               t0_s_r;
	reg               idx_m_r;
	reg               idx_s_r;
	reg               idx_d_r;
	reg [7:0]         s1_nxt;
	reg [7:0]         s2_nxt;
	wire              dor_reset_w;
	wire              core_reset_w;
	wire              wake_w;
	wire              idx_rise;
	wire              wp_rise;
	wire              mismatch;
	wire [7:0]        s3_w;

	function is_write_class;
		input [2:0] c;
		begin
			is_write_class = (c == `FRS_CMD_WRITE) || (c == `FRS_CMD_WRITE_DEL) || (c == `FRS_CMD_FORMAT);
		end
	endfunction

	function is_data_class;
		input [2:0] c;
		begin
			is_data_class = (c == `FRS_CMD_READ) || (c == `FRS_CMD_READ_DEL) ||
				(c == `FRS_CMD_WRITE) || (c == `FRS_CMD_WRITE_DEL);
		end
	endfunction

	frs_reset_ctrl u_rst (
		.clock             (clock),
		.nrst              (nrst),
		.dor_reset_set     (dor_reset_set),
		.dor_reset_clear   (dor_reset_clear),
		.rate_reset_pulse  (rate_reset_pulse),
		.dor_reset_r       (dor_reset_w),
		.core_reset_r      (core_reset_w),
		.power_down_exit_r (wake_w)
	);

	// Pin synchronisers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wp_m_r  <= 1'b0;
			wp_s_r  <= 1'b0;
			wp_d_r  <= 1'b0;
			t0_m_r  <= 1'b0;
			t0_s_r  <= 1'b0;
			idx_m_r <= 1'b1;
			idx_s_r <= 1'b1;
			idx_d_r <= 1'b1;
		end else begin
			wp_m_r  <= write_protect_input;
			wp_s_r  <= wp_m_r;
			wp_d_r  <= wp_s_r;
			t0_m_r  <= track_zero_input;
			t0_s_r  <= t0_m_r;
			idx_m_r <= index_pulse_input;
			idx_s_r <= idx_m_r;
			idx_d_r <= idx_s_r;
		end
	end

	// Index input is active low
	assign idx_rise = idx_d_r & ~idx_s_r;
	assign wp_rise  = wp_s_r & ~wp_d_r;
	assign mismatch = id_valid && (id_track != internal_track);

	// Byte three assembled live from pins and drive outputs
	assign s3_w = `FRS_S3_FIXED |
		({7'h00, wp_s_r} << `FRS_S3_WP) |
		({7'h00, t0_s_r} << `FRS_S3_TRACK_ZERO_INPUT) |
		({7'h00, head_side_output} << `FRS_S3_HEAD) |
		{6'h00, drive_select_out};

	// Live error accumulation while executing
	always @* begin
		s1_nxt = s1_live_r;
		s2_nxt = s2_live_r;
		if ((sector_num == `FRS_LAST_SECTOR && cmd_end == 1'b0 && id_valid) ||
			(cmd_end && is_data_class(class_r) && !terminal_count))
			s1_nxt[`FRS_S1_END_CYL] = 1'b1;
		if (id_crc_err || data_crc_err)
			s1_nxt[`FRS_S1_CRC] = 1'b1;
		if (service_late)
			s1_nxt[`FRS_S1_OVERRUN] = 1'b1;
		if ((sector_not_found && (class_r == `FRS_CMD_READ || class_r == `FRS_CMD_READ_DEL)) ||
			(id_crc_err && class_r == `FRS_CMD_READ_ID) ||
			(sequence_err && class_r == `FRS_CMD_READ_TRACK))
			s1_nxt[`FRS_S1_NO_SECTOR] = 1'b1;
		if (wp_rise && is_write_class(class_r))
			s1_nxt[`FRS_S1_WP_VIOL] = 1'b1;
		if ((idx_rise && !id_seen_r && index_cnt_r == `FRS_INDEX_LIMIT - 2'h1) || data_mark_missing)
			s1_nxt[`FRS_S1_NO_ID_MARK] = 1'b1;
		if ((deleted_mark_seen && class_r == `FRS_CMD_READ) ||
			(normal_mark_seen && class_r == `FRS_CMD_READ_DEL))
			s2_nxt[`FRS_S2_CTRL_MARK] = 1'b1;
		if (data_crc_err)
			s2_nxt[`FRS_S2_DATA_CRC] = 1'b1;
		if (mismatch)
			s2_nxt[`FRS_S2_TRK_MISMATCH] = 1'b1;
		if (mismatch && id_track == `FRS_BAD_TRACK)
			s2_nxt[`FRS_S2_BAD_TRK] = 1'b1;
		if (data_mark_missing)
			s2_nxt[`FRS_S2_NO_DATA_MARK] = 1'b1;
	end

	// Command tracking, latch and result presentation
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r         <= ST_IDLE;
			class_r         <= `FRS_CMD_NONE;
			index_cnt_r     <= 2'h0;
			id_seen_r       <= 1'b0;
			s1_live_r       <= `FRS_RESET_VAL;
			s2_live_r       <= `FRS_RESET_VAL;
			s1_r            <= `FRS_RESET_VAL;
			s2_r            <= `FRS_RESET_VAL;
			data_out_r      <= `FRS_RESET_VAL;
			idle_r          <= 1'b1;
			poll_enable_r   <= 1'b1;
			dor_reset_out_r <= 1'b1;
			awake_r         <= 1'b0;
			specify_r       <= `FRS_RESET_VAL;
		end else begin
			dor_reset_out_r <= dor_reset_w;
			awake_r         <= wake_w;
			if (specify_write)
				specify_r <= specify_in;
			if (core_reset_w) begin
				state_r       <= ST_IDLE;
				class_r       <= `FRS_CMD_NONE;
				index_cnt_r   <= 2'h0;
				id_seen_r     <= 1'b0;
				s1_live_r     <= `FRS_RESET_VAL;
				s2_live_r     <= `FRS_RESET_VAL;
				s1_r          <= `FRS_RESET_VAL;
				s2_r          <= `FRS_RESET_VAL;
				data_out_r    <= `FRS_RESET_VAL;
				idle_r        <= 1'b1;
				poll_enable_r <= 1'b1;
			end else begin
				if (cfg_write)
					poll_enable_r <= ~cfg_poll_disable;
				case (state_r)
					ST_IDLE: begin
						idle_r <= 1'b1;
						if (cmd_start) begin
							state_r     <= ST_EXEC;
							class_r     <= cmd_class;
							index_cnt_r <= 2'h0;
							id_seen_r   <= 1'b0;
							s1_live_r   <= `FRS_RESET_VAL;
							s2_live_r   <= `FRS_RESET_VAL;
							idle_r      <= 1'b0;
						end
					end
					ST_EXEC: begin
						s1_live_r <= s1_nxt;
						s2_live_r <= s2_nxt;
						if (id_mark_seen)
							id_seen_r <= 1'b1;
						if (idx_rise && index_cnt_r != `FRS_INDEX_LIMIT)
							index_cnt_r <= index_cnt_r + 2'h1;
						if (cmd_end) begin
							s1_r    <= s1_nxt;
							s2_r    <= s2_nxt;
							state_r <= ST_HOLD;
						end
					end
					ST_HOLD: begin
						if (result_read) begin
							case (result_sel)
								`FRS_SEL_ONE:   data_out_r <= s1_r & 8'hB7;
								`FRS_SEL_TWO:   data_out_r <= s2_r & 8'h73;
								`FRS_SEL_THREE: data_out_r <= s3_w;
								default:        data_out_r <= `FRS_RESET_VAL;
							endcase
						end
						if (results_done) begin
							state_r <= ST_IDLE;
							idle_r  <= 1'b1;
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// *** testbench/frs_drive_model.sv ***
`timescale 1ns/1ps
module frs_drive_model (
	input  wire clock,
	input  wire wp_lvl,
	input  wire t0_lvl,
	input  wire idx_go,
	output reg  write_protect_input = 1'b0,
	output reg  track_zero_input = 1'b0,
	output wire index_pulse_input
);
	reg [5:0] cnt_r = 6'h00;
	// Two index pulses, four cycles low each, per request
	assign index_pulse_input = ~(cnt_r != 6'h00 && cnt_r[3:2] == 2'h3);
	always @(posedge clock) begin
		write_protect_input <= wp_lvl;
		track_zero_input <= t0_lvl;
		cnt_r <= idx_go ? 6'h20 : (cnt_r != 6'h00 ? cnt_r - 6'h01 : cnt_r);
	end
endmodule

// *** testbench/frs_result_status_props.sv ***
`timescale 1ns/1ps
module frs_result_status_props (
	input wire       clock,
	input wire       nrst,
	input wire       result_read,
	input wire [1:0] result_sel,
	input wire       results_done,
	input wire       dor_reset_set,
	input wire       dor_reset_clear,
	input wire       rate_reset_pulse,
	input wire       head_side_output,
	input wire [1:0] drive_select_out,
	input wire [7:0] data_out_r,
	input wire       idle_r,
	input wire       dor_reset_out_r,
	input wire       awake_r
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_byte_one_zeros: assert property (result_read && result_sel == 2'h1 |=> (data_out_r & 8'h48) == 8'h00)
		else $error("byte one unused bits set");
	a_byte_two_zeros: assert property (result_read && result_sel == 2'h2 |=> (data_out_r & 8'h8C) == 8'h00)
		else $error("byte two unused bits set");
	a_byte_three_fixed: assert property (result_read && result_sel == 2'h3 |=> (data_out_r & 8'hA8) == 8'h28)
		else $error("byte three fixed bits wrong");
	a_byte_three_mirror: assert property (result_read && result_sel == 2'h3 && $stable({head_side_output,
		drive_select_out}) |=> data_out_r[2:0] == $past({head_side_output, drive_select_out}))
		else $error("byte three head or drive bits wrong");
	a_no_select_zero: assert property (result_read && result_sel == 2'h0 |=> data_out_r == 8'h00)
		else $error("unselected read not zero");
	a_dor_set_wins: assert property (dor_reset_set |-> ##2 dor_reset_out_r)
		else $error("output register reset not set");
	a_dor_reset_held: assert property (dor_reset_out_r && !dor_reset_clear && !$past(dor_reset_clear)
		|=> dor_reset_out_r)
		else $error("output register reset dropped by itself");
	a_rate_reset_wakes: assert property (rate_reset_pulse |-> ##[1:2] awake_r)
		else $error("rate reset did not wake core");
	a_done_to_idle: assert property (results_done |=> idle_r)
		else $error("no idle after results read");
	a_result_stands: assert property (!result_read && !dor_reset_set && !dor_reset_out_r && !rate_reset_pulse
		&& !$past(rate_reset_pulse) && !$past(rate_reset_pulse, 2) && !$past(dor_reset_set)
		|=> $stable(data_out_r))
		else $error("result byte changed without read");
endmodule
bind frs_result_status frs_result_status_props u_props (.clock(clock), .nrst(nrst), .result_read(result_read),
	.result_sel(result_sel), .results_done(results_done), .dor_reset_set(dor_reset_set),
	.dor_reset_clear(dor_reset_clear), .rate_reset_pulse(rate_reset_pulse), .head_side_output(head_side_output),
	.drive_select_out(drive_select_out), .data_out_r(data_out_r), .idle_r(idle_r),
	.dor_reset_out_r(dor_reset_out_r), .awake_r(awake_r));

// *** testbench/frs_result_status_tb.sv ***
`timescale 1ns/1ps
module frs_result_status_tb;
	reg        clock = 1'b0, nrst = 1'b0, cst = 1'b0, cend = 1'b0, tc = 1'b0, idv = 1'b0;
	reg        rrd = 1'b0, rdone = 1'b0, head = 1'b0, dset = 1'b0, dclr = 1'b0, rrst = 1'b0;
	reg        cdis = 1'b0, cwr = 1'b0, swr = 1'b0, wp = 1'b0, t0 = 1'b0, idx_go = 1'b0, idm = 1'b0;
	reg  [2:0] ccls = 3'h0;
	reg  [1:0] rsel = 2'h0, ds = 2'h0;
	reg  [7:0] sec = 8'h01, trk = 8'h03, ev = 8'h00;
	wire       wp_pin, t0_pin, idx_pin, idle, poll, dor_out, awake;
	wire [7:0] dout, spec;
	integer    n_errors = 0;
	integer    samples_checked = 0;
	always #12.5 clock = ~clock;
	frs_drive_model u_drive (.clock(clock), .wp_lvl(wp), .t0_lvl(t0), .idx_go(idx_go),
		.write_protect_input(wp_pin), .track_zero_input(t0_pin), .index_pulse_input(idx_pin));
	frs_result_status u_dut (.clock(clock), .nrst(nrst), .cmd_start(cst), .cmd_class(ccls), .cmd_end(cend),
		.terminal_count(tc), .sector_num(sec), .id_track(trk), .internal_track(8'h03), .id_valid(idv),
		.id_crc_err(ev[0]), .data_crc_err(ev[1]), .service_late(ev[2]), .sector_not_found(ev[3]),
		.sequence_err(ev[4]), .index_pulse_input(idx_pin), .id_mark_seen(idm), .data_mark_missing(ev[5]),
		.deleted_mark_seen(ev[6]), .normal_mark_seen(ev[7]), .write_protect_input(wp_pin),
		.track_zero_input(t0_pin), .head_side_output(head), .drive_select_out(ds), .result_read(rrd),
		.result_sel(rsel), .results_done(rdone), .dor_reset_set(dset), .dor_reset_clear(dclr),
		.rate_reset_pulse(rrst), .cfg_poll_disable(cdis), .cfg_write(cwr), .specify_in(8'hA5),
		.specify_write(swr), .data_out_r(dout), .idle_r(idle), .poll_enable_r(poll),
		.dor_reset_out_r(dor_out), .awake_r(awake), .specify_r(spec));
	task tick(input integer n);
		begin
			repeat (n) @(posedge clock);
			#2;
		end
	endtask
	task stop_test;
		begin
			if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [8*6-1:0] nm, input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task rd(input [1:0] s, input [7:0] e);
		begin
			rsel = s;
			rrd = 1'b1;
			tick(1);
			rrd = 1'b0;
			tick(1);
			chk("byte", dout, e);
		end
	endtask
	task pulse_rst(input [2:0] w);
		begin
			{dset, dclr, rrst} = w;
			tick(1);
			{dset, dclr, rrst} = 3'h0;
			tick(4);
		end
	endtask
	// Runs one command; d[0] raises write protect, d[1] asks for two index pulses
	task run(input [2:0] c, input [8:0] e, input t, input [15:0] ts, input [1:0] d, input [15:0] x);
		integer i;
		begin
			ev = 8'h04;
			tick(1);
			ev = 8'h00;
			ccls = c;
			cst = 1'b1;
			tick(1);
			cst = 1'b0;
			{trk, sec} = ts;
			wp = d[0];
			idx_go = d[1];
			tick(1);
			idx_go = 1'b0;
			{idv, ev} = e;
			tick(1);
			{idv, ev} = 9'h000;
			tick(d != 2'h0 ? 40 : 1);
			tc = t;
			cend = 1'b1;
			tick(1);
			{cend, tc} = 2'h0;
			rd(2'h1, x[15:8]);
			rd(2'h2, x[7:0]);
			rd(2'h3, {1'b0, wp, 1'b1, t0, 1'b1, head, ds});
			rd(2'h0, 8'h00);
			rdone = 1'b1;
			tick(1);
			rdone = 1'b0;
			for (i = 0; i < 20 && idle !== 1'b1; i = i + 1) tick(1);
			chk("idle", {7'h00, idle}, 8'h01);
			if (idle !== 1'b1) stop_test;
			{wp, trk, sec} = 17'h00301;
			tick(4);
		end
	endtask
	initial begin
		tick(8);
		chk("rst", {4'h0, idle, poll, dor_out, awake}, 8'h0E);
		chk("spec", spec, 8'h00);
		nrst = 1'b1;
		pulse_rst(3'h1);
		chk("dor", {7'h00, dor_out}, 8'h01);
		pulse_rst(3'h2);
		swr = 1'b1;
		{cwr, cdis} = 2'h3;
		tick(1);
		{swr, cwr, cdis} = 3'h0;
		chk("spec", spec, 8'hA5);
		chk("poll", {7'h00, poll}, 8'h00);
		pulse_rst(3'h1);
		chk("spec", spec, 8'hA5);
		chk("poll", {7'h00, poll}, 8'h01);
		chk("dor", {7'h00, dor_out}, 8'h00);
		pulse_rst(3'h6);
		chk("dor", {7'h00, dor_out}, 8'h01);
		pulse_rst(3'h2);
		{head, ds} = 3'h6;
		run(3'h1, 9'h002, 1'b1, 16'h0301, 2'h0, 16'h2020);
		run(3'h1, 9'h001, 1'b1, 16'h0301, 2'h0, 16'h2000);
		run(3'h1, 9'h004, 1'b1, 16'h0301, 2'h0, 16'h1000);
		run(3'h2, 9'h008, 1'b1, 16'h0301, 2'h0, 16'h0400);
		run(3'h4, 9'h010, 1'b1, 16'h0301, 2'h0, 16'h0400);
		run(3'h3, 9'h001, 1'b1, 16'h0301, 2'h0, 16'h2400);
		t0 = 1'b1;
		run(3'h1, 9'h020, 1'b1, 16'h0301, 2'h0, 16'h0101);
		run(3'h1, 9'h040, 1'b1, 16'h0301, 2'h0, 16'h0040);
		run(3'h2, 9'h080, 1'b1, 16'h0301, 2'h0, 16'h0040);
		run(3'h2, 9'h040, 1'b1, 16'h0301, 2'h0, 16'h0000);
		run(3'h1, 9'h000, 1'b0, 16'h0301, 2'h0, 16'h8000);
		run(3'h5, 9'h000, 1'b1, 16'h0301, 2'h1, 16'h0200);
		run(3'h6, 9'h000, 1'b1, 16'h0301, 2'h1, 16'h0200);
		run(3'h7, 9'h000, 1'b1, 16'h0301, 2'h1, 16'h0200);
		run(3'h1, 9'h000, 1'b1, 16'h0301, 2'h1, 16'h0000);
		run(3'h1, 9'h100, 1'b1, 16'h0501, 2'h0, 16'h0010);
		run(3'h1, 9'h100, 1'b1, 16'hFF01, 2'h0, 16'h0012);
		run(3'h1, 9'h100, 1'b1, 16'h03FF, 2'h0, 16'h8000);
		run(3'h1, 9'h000, 1'b1, 16'h0301, 2'h2, 16'h0100);
		idm = 1'b1;
		run(3'h1, 9'h000, 1'b1, 16'h0301, 2'h2, 16'h0000);
		idm = 1'b0;
		ccls = 3'h5;
		cst = 1'b1;
		tick(1);
		cst = 1'b0;
		tick(2);
		nrst = 1'b0;
		tick(2);
		chk("abort", {6'h00, idle, dor_out}, 8'h03);
		nrst = 1'b1;
		pulse_rst(3'h2);
		run(3'h1, 9'h000, 1'b1, 16'h0301, 2'h0, 16'h0000);
		stop_test;
	end
endmodule
